// file: hw/lvf_bank.sv
// Valid and dropped frame counter bank for the host UART port and both daisy-chain ports, APB slave.
// Assumes APB on clk_sys, frame event strobes from same-domain link logic.
// Operation
// R1: Host UART port valid frames counted in 16 bits, high byte then low byte.
// R2: Upper chain port valid frames counted in 16 bits, high and low bytes.
// R3: Lower chain port valid frames counted in 16 bits, high and low bytes.
// R4: Valid-frame counter stops at all ones, never wraps.
// R5: Reading a dropped-frame count snapshots valid count and clears running counter.
// R6: Each port has 8-bit dropped count, read latches it and clears both.
// R7: Valid bytes read the snapshot while running counter keeps counting.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module lvf_bank (
	input wire logic clk_sys,                            // System clock, 100 MHz
	input wire logic rst_b,                              // Synchronous reset, active low
	input wire logic psel,                               // APB select
	input wire logic penable,                            // APB enable
	input wire logic pwrite,                             // APB direction
	input wire logic [lvf_pkg::LVF_ADDR_W-1:0] paddr,    // APB byte address
	input wire logic [31:0] pwdata,                      // APB write data, ignored
	output logic [31:0] prdata,                          // APB read data
	output logic pready,                                 // APB ready
	output logic pslverr,                                // APB error
	input wire logic [lvf_pkg::LVF_PORTS-1:0] good_evt,  // Valid frame pulse per port
	input wire logic [lvf_pkg::LVF_PORTS-1:0] drop_evt   // Dropped frame pulse per port
);
	import lvf_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic err;
	} lvf_bus_s;

	lvf_bus_s st;
	lvf_bus_s next_st;

	logic [LVF_GOOD_W-1:0] good_snap [LVF_PORTS];
	logic [LVF_DROP_W-1:0] drop_snap [LVF_PORTS];
	logic [LVF_PORTS-1:0] snap;
	logic setup;
	logic rd_setup;
	logic [11:0] idx;

	assign setup = psel && !penable;
	assign rd_setup = setup && !pwrite && paddr[1:0] == 2'b00;
	assign idx = 12'(paddr[LVF_ADDR_W-1:2]);

	// Map a dropped-count register index to its port, or LVF_PORTS for any other index
	function automatic logic [1:0] drop_port(input logic [11:0] i);
		unique case (i)
			LVF_IDX_UART_DROP: drop_port = 2'(LVF_PORT_UART);
			LVF_IDX_UPPER_DROP: drop_port = 2'(LVF_PORT_UPPER);
			LVF_IDX_LOWER_DROP: drop_port = 2'(LVF_PORT_LOWER);
			default: drop_port = 2'(LVF_PORTS);
		endcase
	endfunction : drop_port

	// ----------------------------------------------------------------
	// Per-port counters
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LVF_PORTS; g++) begin : g_port
			assign snap[g] = rd_setup && drop_port(idx) == 2'(g); // R5 R6
			lvf_port_cnt #(
				.GOOD_W(LVF_GOOD_W),
				.DROP_W(LVF_DROP_W)
			) u_cnt (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.good_evt(good_evt[g]), // R1 R2 R3
				.drop_evt(drop_evt[g]),
				.snap(snap[g]),
				.good_snap(good_snap[g]),
				.drop_snap(drop_snap[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// APB read path: no wait state, answer in the first access-phase cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ready = 1'b0;
		next_st.err = 1'b0;
		if (setup) begin
			next_st.ready = 1'b1;
			next_st.rdata = '0;
			if (pwrite || paddr[1:0] != 2'b00) begin
				next_st.err = 1'b1;
			end else begin
				unique case (idx)
					LVF_IDX_UART_DROP: next_st.rdata = 32'(drop_snap[LVF_PORT_UART]); // R6
					LVF_IDX_UPPER_DROP: next_st.rdata = 32'(drop_snap[LVF_PORT_UPPER]);
					LVF_IDX_LOWER_DROP: next_st.rdata = 32'(drop_snap[LVF_PORT_LOWER]);
					LVF_IDX_UART_HI: next_st.rdata = 32'(good_snap[LVF_PORT_UART][15:8]); // R1 R7
					LVF_IDX_UART_LO: next_st.rdata = 32'(good_snap[LVF_PORT_UART][7:0]); // R1 R7
					LVF_IDX_UPPER_HI: next_st.rdata = 32'(good_snap[LVF_PORT_UPPER][15:8]); // R2
					LVF_IDX_UPPER_LO: next_st.rdata = 32'(good_snap[LVF_PORT_UPPER][7:0]); // R2
					LVF_IDX_LOWER_HI: next_st.rdata = 32'(good_snap[LVF_PORT_LOWER][15:8]); // R3
					LVF_IDX_LOWER_LO: next_st.rdata = 32'(good_snap[LVF_PORT_LOWER][7:0]); // R3
					default: next_st.err = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.err;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [15:0] u_run0;
	logic [15:0] u_run1;
	logic [15:0] u_run2;
	logic [7:0] u_peek_drop0;
	assign u_run0 = g_port[0].u_cnt.st.good_run;
	assign u_run1 = g_port[1].u_cnt.st.good_run;
	assign u_run2 = g_port[2].u_cnt.st.good_run;
	assign u_peek_drop0 = g_port[0].u_cnt.st.drop_run;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_snap_port: assert property (snap[0] |=> drop_snap[0] == $past(u_peek_drop0)) // R6
		else $error("dropped count not captured on read");
	chk_sat_hold: assert property (u_run0 == 16'hffff && !snap[0] |=> u_run0 == 16'hffff) // R4
		else $error("good counter wrapped at saturation");
	chk_clear_run: assert property (snap[0] |=> u_run0 == 16'h0000) // R5
		else $error("running counter not cleared");
	chk_count_up: assert property (good_evt[1] && !snap[1] && u_run1 != 16'hffff
		|=> u_run1 == $past(u_run1) + 16'h0001) // R2
		else $error("upper good count did not step");
	chk_lower_up: assert property (good_evt[2] && !snap[2] && u_run2 != 16'hffff
		|=> u_run2 == $past(u_run2) + 16'h0001) // R3
		else $error("lower good count did not step");
	chk_snap_hold: assert property (!snap[0] |=> good_snap[0] == $past(good_snap[0])) // R7
		else $error("good snapshot moved without a read");
	chk_hi_byte: assert property (rd_setup && idx == LVF_IDX_UART_HI
		|=> pready && prdata == 32'(good_snap[0][15:8])) // R1
		else $error("uart high byte wrong");
	chk_ready_one: assert property (setup |=> pready ##1 !pready)
		else $error("pready not a single cycle");

	cov_snap: cover property (snap[0] ##1 good_snap[0] != 16'h0000);
	cov_sat: cover property (u_run0 == 16'hffff);
	cov_err: cover property (pslverr);

endmodule : lvf_bank

// file: hw/lvf_pkg.sv
// Package for the link valid-frame counter bank: register indices, widths, reset values.
// Assumes APB with 32-bit data; printed offsets are not multiples of four, so byte address = 4 * index.
package lvf_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [11:0] LVF_IDX_UART_DROP = 12'h789;
	localparam logic [11:0] LVF_IDX_UPPER_DROP = 12'h78a;
	localparam logic [11:0] LVF_IDX_LOWER_DROP = 12'h78b;
	localparam logic [11:0] LVF_IDX_UART_HI = 12'h78c;
	localparam logic [11:0] LVF_IDX_UART_LO = 12'h78d;
	localparam logic [11:0] LVF_IDX_UPPER_HI = 12'h78e;
	localparam logic [11:0] LVF_IDX_UPPER_LO = 12'h78f;
	localparam logic [11:0] LVF_IDX_LOWER_HI = 12'h790;
	localparam logic [11:0] LVF_IDX_LOWER_LO = 12'h791;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int LVF_ADDR_W = 14;
	localparam int LVF_PORTS = 3;
	localparam int LVF_GOOD_W = 16;
	localparam int LVF_DROP_W = 8;
	localparam logic [15:0] LVF_GOOD_RST = 16'h0000;
	localparam logic [7:0] LVF_DROP_RST = 8'h00;
	localparam logic [7:0] LVF_BYTE_SAT = 8'hff;

	// Port numbering
	localparam int LVF_PORT_UART = 0;
	localparam int LVF_PORT_UPPER = 1;
	localparam int LVF_PORT_LOWER = 2;

endpackage : lvf_pkg

// file: hw/lvf_port_cnt.sv
// One port's frame counters: running good and dropped counts plus their snapshots.
// Assumes event strobes are one-cycle pulses on clk_sys; snap is a one-cycle pulse.
`timescale 1ns/10ps
module lvf_port_cnt #(
	parameter int GOOD_W = lvf_pkg::LVF_GOOD_W, // Good-frame counter width
	parameter int DROP_W = lvf_pkg::LVF_DROP_W  // Dropped-frame counter width
) (
	input wire logic clk_sys,              // System clock
	input wire logic rst_b,                // Synchronous reset, active low
	input wire logic good_evt,             // Valid frame seen
	input wire logic drop_evt,             // Discarded frame seen
	input wire logic snap,                 // Capture and clear
	output logic [GOOD_W-1:0] good_snap,   // Captured good count
	output logic [DROP_W-1:0] drop_snap    // Captured dropped count
);
	import lvf_pkg::*;

	// Refuse widths the saturating counters cannot serve
	if (GOOD_W < 2 || DROP_W < 1) begin : g_bad_width
		$error("lvf_port_cnt: widths too small");
	end

	typedef struct packed {
		logic [GOOD_W-1:0] good_run;
		logic [DROP_W-1:0] drop_run;
		logic [GOOD_W-1:0] good_cap;
		logic [DROP_W-1:0] drop_cap;
	} lvf_cnt_s;

	lvf_cnt_s st;
	lvf_cnt_s next_st;

	always_comb begin
		next_st = st;
		if (snap) begin
			next_st.good_cap = st.good_run; // R5
			next_st.drop_cap = st.drop_run; // R6
			next_st.good_run = '0; // R5
			next_st.drop_run = '0; // R6
		end else begin
			if (good_evt && st.good_run != '1) begin // R4
				next_st.good_run = st.good_run + 1'b1;
			end
			if (drop_evt && st.drop_run != '1) begin
				next_st.drop_run = st.drop_run + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign good_snap = st.good_cap;
	assign drop_snap = st.drop_cap;

endmodule : lvf_port_cnt

// file: tb/lvf_link_src.sv
// Frame event source for the host port and both chain neighbours.
// Assumes clk_sys from the bench.
`timescale 1ns/10ps
module lvf_link_src (
	input wire logic clk_sys, // System clock
	output logic [2:0] good_evt, // Valid frame pulses
	output logic [2:0] drop_evt // Dropped frame pulses
);
	initial begin
		good_evt = 3'h0;
		drop_evt = 3'h0;
	end
	// Frames on one port; gap adds idle cycles between them
	task automatic send(input int p, input int ng, input int nd, input int gap);
		for (int i = 0; i < ng || i < nd; i++) begin
			@(posedge clk_sys);
			good_evt[p] <= (i < ng);
			drop_evt[p] <= (i < nd);
			if (gap > 0) begin
				@(posedge clk_sys);
				good_evt <= 3'h0;
				drop_evt <= 3'h0;
				repeat (gap - 1) @(posedge clk_sys);
			end
		end
		@(posedge clk_sys);
		good_evt <= 3'h0;
		drop_evt <= 3'h0;
	endtask : send
endmodule : lvf_link_src

// file: tb/lvf_bank_tb.sv
// Self-checking bench for the frame counter bank.
// Assumes lvf_link_src drives the frame events.
`timescale 1ns/10ps
module lvf_bank_tb;
	import lvf_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0;
	logic [31:0] pwdata = 32'ha5a5a5a5;
	logic [31:0] prdata, d;
	logic pready, pslverr, e;
	logic [2:0] good_evt, drop_evt;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #5 clk_sys = ~clk_sys;
	lvf_bank DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.good_evt(good_evt), .drop_evt(drop_evt));
	lvf_link_src link (.clk_sys(clk_sys), .good_evt(good_evt), .drop_evt(drop_evt));
	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] idx, input logic [1:0] lo);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, lo};
		@(posedge clk_sys);
		penable <= 1'b1;
		// Wait for the answer; only the bench timeout ends a hang
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		chk("wait_cycles", 32'(n), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input string nm, input logic [11:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 2'h0);
		chk(nm, d, exp);
		chk("pslverr", {31'h0, e}, 32'h0);
	endtask : rd
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 9; i++) rd("rst_val", LVF_IDX_UART_DROP + 12'(i), 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_ports;
		logic [11:0] hi;
		for (int p = 0; p < 3; p++) begin
			hi = LVF_IDX_UART_HI + 12'(2 * p);
			link.send(p, 300 + p, 2 + p, p);
			rd("drop_prev", LVF_IDX_UART_DROP + 12'(p), 32'h0);
			rd("good_hi", hi, 32'h1);
			rd("good_lo", hi + 12'h1, 32'h2c + 32'(p));
			rd("drop", LVF_IDX_UART_DROP + 12'(p), 32'h2 + 32'(p));
			rd("good_clr", hi + 12'h1, 32'h0);
		end
		$display("test ports done");
	endtask : t_ports
	task automatic t_bg;
		link.send(0, 5, 0, 1);
		rd("bg_held", LVF_IDX_UART_LO, 32'h0);
		link.send(0, 2, 0, 0);
		rd("bg_drop", LVF_IDX_UART_DROP, 32'h0);
		rd("bg_new", LVF_IDX_UART_LO, 32'h7);
		$display("test background done");
	endtask : t_bg
	task automatic t_sat;
		link.send(0, 65537, 300, 0);
		rd("sat_drop0", LVF_IDX_UART_DROP, 32'h0);
		rd("sat_hi", LVF_IDX_UART_HI, 32'hff);
		apb(1'b1, LVF_IDX_UART_DROP, 2'h0);
		chk("wr_err", {31'h0, e}, 32'h1);
		apb(1'b0, 12'h792, 2'h0);
		chk("unmap_err", {31'h0, e}, 32'h1);
		chk("unmap_data", d, 32'h0);
		apb(1'b0, LVF_IDX_UART_LO, 2'h1);
		chk("unalign_err", {31'h0, e}, 32'h1);
		rd("sat_lo", LVF_IDX_UART_LO, 32'hff);
		rd("sat_drop", LVF_IDX_UART_DROP, 32'hff);
		$display("test saturate done");
	endtask : t_sat
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_ports();
		t_bg();
		t_sat();
		end_of_test();
	end
endmodule : lvf_bank_tb
